//--- core/gprs_regs.sv
// Gigabit role control and status register bank behind an APB slave.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module gprs_regs
(
  // Clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 arst_n_i,
  // APB slave
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [7:0]           paddr_i,
  input  wire logic [31:0]          pwdata_i,
  output logic [31:0]               prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  // Mode straps from pins
  input  wire logic [1:0]           mode_strap_i,
  // Link and auto-negotiation logic
  input  wire logic                 np_rx_valid_i,
  input  wire logic [15:0]          np_rx_word_i,
  input  wire gprs_pkg::gprs_link_t link_i,
  input  wire logic                 soft_reset_i,
  input  wire logic                 logic_reset_i,
  // Role configuration and idle error saturation flag towards the link logic
  output gprs_pkg::gprs_ctrl_t      ctrl_o,
  output logic                      idle_err_sat_o
);
  import gprs_pkg::*;

  // True when the bus address selects the given register slot. The low two
  // address bits must be zero: a misaligned access selects nothing and is
  // answered with an error rather than aliasing onto a neighbour.
  function automatic logic reg_hit(input logic [7:0] addr, input logic [5:0] idx);
    reg_hit = (addr[1:0] == 2'b00) & (addr == reg_addr(idx));
  endfunction

  // Map the stored test code onto the modes the transmitter knows. Reserved
  // codes fall back to normal operation, so a stray write cannot start an
  // undefined test pattern on the line.
  function automatic gprs_test_t test_decode(input logic [2:0] code);
    case (code)
      3'h0:    test_decode = GPRS_TM_NORMAL;
      3'h1:    test_decode = GPRS_TM_WAVEFORM;
      3'h2:    test_decode = GPRS_TM_JITTER_MASTER;
      3'h3:    test_decode = GPRS_TM_JITTER_SLAVE;
      3'h4:    test_decode = GPRS_TM_DISTORTION;
      default: test_decode = GPRS_TM_NORMAL;
    endcase
  endfunction

  // Add one error to a count, holding at all ones instead of wrapping.
  function automatic logic [7:0] sat_inc(input logic [7:0] cnt);
    if (cnt == IDLE_CNT_MAX)
      sat_inc = cnt;
    else
      sat_inc = 8'(cnt + 8'h01);
  endfunction

  typedef enum logic {
    GPRS_ST_STRAP,
    GPRS_ST_RUN
  } gprs_state_t;

  gprs_state_t state;
  gprs_state_t next_state;
  logic [1:0]  strap_cnt;
  logic [1:0]  next_strap_cnt;
  logic [1:0]  strap_s1;
  logic [1:0]  strap_s2;
  logic [1:0]  strap_s3;
  logic [15:0] np_rx;
  logic [2:0]  test_mode;
  logic [4:0]  role_cfg;
  logic        ms_fault_lh;
  logic [7:0]  idle_cnt;
  logic [31:0] rdata;

  // Bus phase decode.
  wire logic        setup     = psel_i & ~penable_i;
  wire logic        access    = psel_i & penable_i;
  wire logic        rd_setup  = setup & ~pwrite_i;

  // Register select.
  wire logic        hit_np    = reg_hit(paddr_i, NP_RX_IDX);
  wire logic        hit_ctrl  = reg_hit(paddr_i, ROLE_CTRL_IDX);
  wire logic        hit_stat  = reg_hit(paddr_i, ROLE_STAT_IDX);
  wire logic        hit_ext   = reg_hit(paddr_i, EXT_STAT_IDX);
  wire logic        hit_any   = hit_np | hit_ctrl | hit_stat | hit_ext;
  wire logic        ctrl_wr   = access & pwrite_i & hit_ctrl;
  // Read side effects act when read data is captured in the setup cycle,
  // so the returned value and the clear always refer to the same count.
  wire logic        stat_rd   = setup & ~pwrite_i & hit_stat;
  wire logic        strap_ok  = (strap_s2 == strap_s3);
  wire logic        strap_ld  = (state == GPRS_ST_STRAP) & (strap_cnt == STRAP_WAIT) & strap_ok;

  // Strap mapping: straps choose the advertised gigabit duplex modes,
  // manual role configuration starts disabled.
  wire logic [4:0]  strap_cfg = {1'b0, 1'b0, 1'b0, strap_s3[1], strap_s3[0]};

  // Control register image. The low byte has no storage behind it: host
  // writes there are dropped and reads return zero.
  wire logic [7:0]  ctrl_rsvd = 8'h00;
  wire logic [15:0] ctrl_word = {test_mode, role_cfg, ctrl_rsvd};

  // Status register fields. Role, receiver and partner ability bits are
  // shown live; only the fault bit is latched, so a short fault pulse is
  // not lost between two host polls.
  wire logic        st_fault     = ms_fault_lh;
  wire logic        st_master    = link_i.resolved_master;
  wire logic        st_local_ok  = link_i.local_rx_ok;
  wire logic        st_remote_ok = link_i.remote_rx_ok;
  // The partner ability bits mean something only once a page was received;
  // this bank holds no page-received flag for the host to check first.
  wire logic        st_peer_full = link_i.partner_gig_full_duplex;
  wire logic        st_peer_half = link_i.partner_gig_half_duplex;
  wire logic [1:0]  st_reserved  = 2'b00;
  wire logic [7:0]  st_idle_cnt  = idle_cnt;

  // Status register image.
  wire logic [15:0] stat_word    = {st_fault, st_master, st_local_ok, st_remote_ok,
                                    st_peer_full, st_peer_half, st_reserved, st_idle_cnt};

  // Partner next page fields. Toggle and acknowledge-2 are kept exactly as
  // the partner sent them; the link logic owns their meaning.
  wire logic        np_next_pg   = np_rx[15];
  wire logic        np_ack       = np_rx[14];
  wire logic        np_msg_pg    = np_rx[13];
  wire logic        np_ack2      = np_rx[12];
  wire logic        np_toggle    = np_rx[11];
  wire logic [10:0] np_code      = np_rx[10:0];
  wire logic [15:0] np_word      = {np_next_pg, np_ack, np_msg_pg, np_ack2, np_toggle, np_code};

  // Read multiplexer; unmapped addresses read zero.
  wire logic [15:0] rd_word = hit_np   ? np_word :
                              hit_ctrl ? ctrl_word :
                              hit_stat ? stat_word :
                              hit_ext  ? EXT_STAT_VAL :
                              16'h0000;

  // Next fault latch: an event in the read cycle survives the clear, so a
  // fault that arrives while the host is reading is reported on the next
  // read instead of being lost.
  wire logic        fault_set  = link_i.ms_fault;
  wire logic        fault_hold = ms_fault_lh & ~stat_rd;
  wire logic        next_fault = fault_set | fault_hold;

  // Next idle counter: clear, then count, then saturate. Clearing first
  // means an error in the clearing cycle is counted, not lost.
  wire logic        clr_by_rd  = stat_rd;
  wire logic        clr_by_rst = soft_reset_i | logic_reset_i;
  wire logic        cnt_clr    = clr_by_rd | clr_by_rst;
  wire logic [7:0]  cnt_base   = cnt_clr ? IDLE_CNT_RST : idle_cnt;
  wire logic [7:0]  next_cnt   = link_i.idle_error ? sat_inc(cnt_base) :
                                 cnt_base;

  // Test mode decode; reserved codes run as normal operation.
  wire gprs_test_t  test_sel   = test_decode(test_mode);

  // Strap synchroniser. The pins are asynchronous to the clock, so the first
  // stage may go metastable; only the second stage reads it. A level counts
  // once the second and third stage agree, which also filters a pin that is
  // still bouncing when reset is released.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      strap_s1 <= 2'b00;
    else
      strap_s1 <= mode_strap_i;
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      strap_s2 <= 2'b00;
    else
      strap_s2 <= strap_s1;
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      strap_s3 <= 2'b00;
    else
      strap_s3 <= strap_s2;
  end

  // Strap wait sequencer: count edges after release, then load once. If the
  // straps never settle the load never happens and the role bits stay clear unless a host writes them.
  always_comb
  begin
    next_state     = state;
    next_strap_cnt = strap_cnt;
    case (state)
      GPRS_ST_STRAP:
      begin
        if (strap_cnt != STRAP_WAIT)
          next_strap_cnt = 2'(strap_cnt + 2'b01);
        if (strap_ld)
          next_state = GPRS_ST_RUN;
      end
      GPRS_ST_RUN:
        next_state = GPRS_ST_RUN;
      default:
        next_state = GPRS_ST_STRAP;
    endcase
  end

  // After release, wait for the synchroniser to fill before loading straps.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state     <= GPRS_ST_STRAP;
      strap_cnt <= 2'b00;
    end
    else
    begin
      state     <= next_state;
      strap_cnt <= next_strap_cnt;
    end
  end

  // Next control values. A strap load in the same cycle as a host write wins
  // for the role bits and drops the write entirely, so the register never
  // holds a mix of strap and host values; hosts wait for the load to finish.
  wire logic        ctrl_take      = ctrl_wr & ~strap_ld;
  wire logic [2:0]  next_test_mode = ctrl_take ? pwdata_i[CTRL_TEST_LSB +: 3] :
                                     test_mode;
  wire logic [4:0]  next_role_cfg  = strap_ld  ? strap_cfg :
                                     ctrl_take ? pwdata_i[CTRL_ADV_HALF +: 5] :
                                     role_cfg;

  // Test mode field. Reserved codes are stored and read back as written.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      test_mode <= TEST_RST;
    else
      test_mode <= next_test_mode;
  end

  // Role configuration bits 12 to 8. They clear on reset and take the strap
  // levels once the synchroniser has settled.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      role_cfg <= 5'h00;
    else
      role_cfg <= next_role_cfg;
  end

  // Partner next page capture. The word is taken whole on the strobe, so
  // the host never sees a page with fields from two different pages.
  // Until the first page arrives it reads the reset pattern.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      np_rx <= NP_RX_RST;
    else if (np_rx_valid_i)
      np_rx <= np_rx_word_i;
  end

  // Latched configuration fault.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      ms_fault_lh <= 1'b0;
    else
      ms_fault_lh <= next_fault;
  end

  // Idle error counter. Hardware reset clears it here; the soft and logic
  // resets clear it through the next-value path so that they stay synchronous.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      idle_cnt <= IDLE_CNT_RST;
    else
      idle_cnt <= next_cnt;
  end

  // Read data is captured in the setup cycle and held through the access.
  // Capturing early lets the slave answer with no wait state, and it means
  // the word returned is the one that the clear-on-read side effect saw.
  // The upper half of the bus word is always zero.
  wire logic [31:0] next_rdata = {16'h0000, rd_word};

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rdata <= 32'h0000_0000;
    else if (rd_setup)
      rdata <= next_rdata;
  end

  // Control register fields.
  wire logic        cf_man_en    = role_cfg[CTRL_MAN_EN - CTRL_ADV_HALF];
  wire logic        cf_man_role  = role_cfg[CTRL_MAN_ROLE - CTRL_ADV_HALF];
  wire logic        cf_multiport = role_cfg[CTRL_PORT_TYPE - CTRL_ADV_HALF];
  wire logic        cf_adv_full  = role_cfg[CTRL_ADV_FULL - CTRL_ADV_HALF];
  wire logic        cf_adv_half  = role_cfg[0];

  // Manual role and port type pass on only while manual enable reads 0;
  // the stored bits still read back unchanged.
  assign ctrl_o.test_mode   = test_sel;
  assign ctrl_o.manual_en   = cf_man_en;
  assign ctrl_o.manual_role = cf_man_role & ~cf_man_en;
  assign ctrl_o.multiport   = cf_multiport & ~cf_man_en;
  assign ctrl_o.adv_full    = cf_adv_full;
  assign ctrl_o.adv_half    = cf_adv_half;
  assign idle_err_sat_o     = (idle_cnt == IDLE_CNT_MAX);

  // Zero-wait slave; unmapped or misaligned addresses answer with an error.
  // Keeping ready high costs nothing here, because every register is read
  // from flip-flops captured one cycle early, in the setup phase.
  wire logic        resp_err = access & ~hit_any;

  assign prdata_o  = rdata;
  assign pready_o  = 1'b1;
  assign pslverr_o = resp_err;

endmodule

`default_nettype wire

//--- core/gprs_pkg.sv
// Package: register map, field layout, reset values and carrier types of the role/status bank.
package gprs_pkg;

  // Register indices; the APB byte address is four times the index.
  localparam logic [5:0] NP_RX_IDX      = 6'h08;
  localparam logic [5:0] ROLE_CTRL_IDX  = 6'h09;
  localparam logic [5:0] ROLE_STAT_IDX  = 6'h0a;
  localparam logic [5:0] EXT_STAT_IDX   = 6'h0f;

  // Control register field positions.
  localparam int CTRL_TEST_LSB   = 13;
  localparam int CTRL_MAN_EN     = 12;
  localparam int CTRL_MAN_ROLE   = 11;
  localparam int CTRL_PORT_TYPE  = 10;
  localparam int CTRL_ADV_FULL   = 9;
  localparam int CTRL_ADV_HALF   = 8;

  // Status register field positions.
  localparam int STAT_FAULT      = 15;
  localparam int STAT_MASTER     = 14;
  localparam int STAT_LOCAL_OK   = 13;
  localparam int STAT_REMOTE_OK  = 12;
  localparam int STAT_LP_FULL    = 11;
  localparam int STAT_LP_HALF    = 10;

  // Reset and fixed values.
  localparam logic [15:0] NP_RX_RST    = 16'h2000;
  localparam logic [2:0]  TEST_RST     = 3'h0;
  localparam logic [15:0] EXT_STAT_VAL = 16'h3000;
  localparam logic [7:0]  IDLE_CNT_RST = 8'h00;
  localparam logic [7:0]  IDLE_CNT_MAX = 8'hff;

  // Cycles to wait after reset release before the strap levels are trusted.
  localparam logic [1:0]  STRAP_WAIT   = 2'h3;

  typedef enum logic [2:0] {
    GPRS_TM_NORMAL,
    GPRS_TM_WAVEFORM,
    GPRS_TM_JITTER_MASTER,
    GPRS_TM_JITTER_SLAVE,
    GPRS_TM_DISTORTION
  } gprs_test_t;

  // Role control fields as seen by the link logic.
  typedef struct packed {
    gprs_test_t test_mode;
    logic       manual_en;
    logic       manual_role;
    logic       multiport;
    logic       adv_full;
    logic       adv_half;
  } gprs_ctrl_t;

  // Status levels and events from the link logic, same clock.
  typedef struct packed {
    logic ms_fault;
    logic resolved_master;
    logic local_rx_ok;
    logic remote_rx_ok;
    logic partner_gig_full_duplex;
    logic partner_gig_half_duplex;
    logic idle_error;
  } gprs_link_t;

  // Byte address of a register index.
  function automatic logic [7:0] reg_addr(input logic [5:0] idx);
    reg_addr = {idx, 2'b00};
  endfunction

endpackage

//--- testbench/gprs_regs_monitor.sv
// Checker for the role/status register bank, watching only its ports.
`timescale 1ns/1ps
`default_nettype none
module gprs_regs_monitor
(
  // Clock and reset
  input wire logic                 mclk_i,
  input wire logic                 arst_n_i,
  // APB
  input wire logic                 psel_i,
  input wire logic                 penable_i,
  input wire logic                 pwrite_i,
  input wire logic [7:0]           paddr_i,
  input wire logic [31:0]          pwdata_i,
  input wire logic [31:0]          prdata_o,
  input wire logic                 pready_o,
  input wire logic                 pslverr_o,
  // Link side
  input wire logic [1:0]           mode_strap_i,
  input wire logic                 np_rx_valid_i,
  input wire logic [15:0]          np_rx_word_i,
  input wire gprs_pkg::gprs_link_t link_i,
  input wire logic                 soft_reset_i,
  input wire logic                 logic_reset_i,
  input wire gprs_pkg::gprs_ctrl_t ctrl_o,
  input wire logic                 idle_err_sat_o
);
  import gprs_pkg::*;
  wire logic       stat_rd = psel_i && !penable_i && !pwrite_i && paddr_i == 8'h28;
  wire logic       idle    = link_i.idle_error;
  wire logic [4:0] stat_lv = link_i[5:1];
  // Manual role and port type are masked while manual configuration is enabled.
  wire logic [7:0] wr_exp  = {(pwdata_i[15:13] > 3'h4) ? 3'h0 : pwdata_i[15:13], pwdata_i[12],
                              pwdata_i[11] & ~pwdata_i[12], pwdata_i[10] & ~pwdata_i[12],
                              pwdata_i[9:8]};
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_stat_rd; stat_rd; endsequence
  sequence s_ctrl_wr; psel_i && penable_i && pwrite_i && paddr_i == 8'h24; endsequence
  property p_ext; psel_i && penable_i && !pwrite_i && paddr_i == 8'h3c |-> prdata_o == 32'h3000;
  endproperty
  property p_stat; s_stat_rd |=> prdata_o[14:10] == $past(stat_lv) && prdata_o[31:16] == 16'h0
    && prdata_o[9:8] == 2'h0; endproperty
  property p_fault; link_i.ms_fault ##1 s_stat_rd |=> prdata_o[15]; endproperty
  property p_wr; s_ctrl_wr |=> ctrl_o == $past(wr_exp); endproperty
  property p_man; ctrl_o.manual_en |-> !ctrl_o.manual_role && !ctrl_o.multiport; endproperty
  property p_test; ctrl_o.test_mode <= GPRS_TM_DISTORTION; endproperty
  property p_sat_hold; idle_err_sat_o && !stat_rd && !soft_reset_i && !logic_reset_i
    |=> idle_err_sat_o; endproperty
  property p_sat_clr; s_stat_rd ##0 !idle |=> !idle_err_sat_o; endproperty
  property p_soft; (soft_reset_i || logic_reset_i) && !idle |=> !idle_err_sat_o; endproperty
  property p_sat_rise; $rose(idle_err_sat_o) |-> $past(idle); endproperty
  a_ext: assert property (p_ext) else $error("extended status word wrong");
  a_stat: assert property (p_stat) else $error("status levels wrong");
  a_fault: assert property (p_fault) else $error("fault not latched");
  a_wr: assert property (p_wr) else $error("control write wrong");
  a_man: assert property (p_man) else $error("manual fields not masked");
  a_test: assert property (p_test) else $error("reserved test code driven");
  a_sat_hold: assert property (p_sat_hold) else $error("counter left saturation");
  a_sat_clr: assert property (p_sat_clr) else $error("counter not cleared on read");
  a_soft: assert property (p_soft) else $error("counter not cleared by reset");
  a_sat_rise: assert property (p_sat_rise) else $error("saturation without error");
endmodule
bind gprs_regs gprs_regs_monitor u_mon (.mclk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .mode_strap_i, .np_rx_valid_i,
  .np_rx_word_i, .link_i, .soft_reset_i, .logic_reset_i, .ctrl_o, .idle_err_sat_o);
`default_nettype wire

//--- testbench/gprs_link_model.sv
// Model of the link logic that feeds status levels, idle errors and partner pages.
`timescale 1ns/1ps
`default_nettype none
module gprs_link_model
(
  input  wire logic           mclk_i,
  output gprs_pkg::gprs_link_t link_o,
  output logic                np_valid_o,
  output logic [15:0]         np_word_o
);
  import gprs_pkg::*;
  initial link_o = '0;
  initial np_valid_o = 1'b0;
  initial np_word_o = 16'h0;
  task automatic send_page(input logic [15:0] w);
    @(posedge mclk_i);
    np_word_o <= w;
    np_valid_o <= 1'b1;
    @(posedge mclk_i);
    np_valid_o <= 1'b0;
    // The word is not held after the strobe, so a late load would show.
    np_word_o <= ~w;
  endtask
  task automatic idle_errs(input int n);
    repeat (n) @(posedge mclk_i) link_o.idle_error <= 1'b1;
    @(posedge mclk_i);
    link_o.idle_error <= 1'b0;
  endtask
  task automatic set_status(input logic [5:0] s);
    @(posedge mclk_i);
    link_o[6:1] <= s;
  endtask
endmodule
`default_nettype wire

//--- testbench/gigabit_phy_mgmt_status_regs_bench.sv
// Self-checking bench for the role/status register bank.
`timescale 1ns/1ps
`default_nettype none
module gigabit_phy_mgmt_status_regs_bench;
  import gprs_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d, x; logic e;} gprs_row_t;
  logic        mclk_i = 1'b0, arst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
  logic        pwrite_i = 1'b0, soft_reset_i = 1'b0, logic_reset_i = 1'b0;
  logic [1:0]  mode_strap_i = 2'h2;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic        pready_o, pslverr_o, np_rx_valid_i, idle_err_sat_o, er;
  logic [15:0] np_rx_word_i;
  gprs_link_t  link_i;
  gprs_ctrl_t  ctrl_o;
  int          err_count = 0, num_checks = 0;
  gprs_row_t   rows [8] = '{'{1'b0, 8'h20, 32'h0, 32'h2000, 1'b0},
    '{1'b0, 8'h3c, 32'h0, 32'h3000, 1'b0}, '{1'b0, 8'h24, 32'h0, 32'h0200, 1'b0},
    '{1'b1, 8'h20, 32'hffff, 32'h0, 1'b0}, '{1'b0, 8'h20, 32'h0, 32'h2000, 1'b0},
    '{1'b1, 8'h24, 32'hffffffff, 32'h0, 1'b0}, '{1'b0, 8'h24, 32'h0, 32'hff00, 1'b0},
    '{1'b0, 8'h30, 32'h0, 32'h0, 1'b1}};
  gprs_regs dut (.mclk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .mode_strap_i, .np_rx_valid_i, .np_rx_word_i, .link_i,
    .soft_reset_i, .logic_reset_i, .ctrl_o, .idle_err_sat_o);
  gprs_link_model lm (.mclk_i, .link_o(link_i), .np_valid_o(np_rx_valid_i),
    .np_word_o(np_rx_word_i));
  always #4 mclk_i = ~mclk_i;
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk("rdata", x, rd);
  endtask
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    err_count++;
    print_verdict();
  end
  initial
  begin
    repeat (8) @(posedge mclk_i);
    chk("reset ctrl", 32'h0, {24'h0, ctrl_o});
    repeat (8) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    repeat (8) @(posedge mclk_i);
    chk("strap adv", 32'h2, {30'h0, ctrl_o.adv_full, ctrl_o.adv_half});
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w)
        chk("rdata", rows[i].x, rd);
      chk("slverr", {31'h0, rows[i].e}, {31'h0, er});
    end
    $display("table tests done");
    // Write all eight test codes; reserved codes 5 to 7 must drive normal operation.
    for (int t = 0; t < 8; t++)
    begin
      apb(1'b1, 8'h24, {16'h0, t[2:0], 13'h0});
      chk("test mode", (t > 4) ? 32'h0 : 32'(t), {29'h0, ctrl_o.test_mode});
    end
    apb(1'b1, 8'h24, 32'h1f00);
    chk("manual on", 32'h13, {27'h0, ctrl_o[4:0]});
    apb(1'b1, 8'h24, 32'h0d00);
    chk("manual off", 32'h0d, {27'h0, ctrl_o[4:0]});
    $display("control tests done");
    lm.set_status(6'h15);
    rdc(8'h28, 32'h5400);
    lm.set_status(6'h0a);
    rdc(8'h28, 32'h2800);
    lm.set_status(6'h20);
    lm.set_status(6'h00);
    rdc(8'h28, 32'h8000);
    rdc(8'h28, 32'h0);
    lm.send_page(16'h5abc);
    rdc(8'h20, 32'h5abc);
    $display("status tests done");
    lm.idle_errs(5);
    rdc(8'h28, 32'h5);
    rdc(8'h28, 32'h0);
    lm.idle_errs(300);
    chk("saturated", 32'h1, {31'h0, idle_err_sat_o});
    rdc(8'h28, 32'hff);
    chk("saturated", 32'h0, {31'h0, idle_err_sat_o});
    for (int k = 0; k < 2; k++)
    begin
      lm.idle_errs(3);
      soft_reset_i <= (k == 0);
      logic_reset_i <= (k == 1);
      @(posedge mclk_i);
      soft_reset_i <= 1'b0;
      logic_reset_i <= 1'b0;
      rdc(8'h28, 32'h0);
    end
    arst_n_i <= 1'b0;
    mode_strap_i <= 2'h1;
    repeat (2) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rdc(8'h20, 32'h2000);
    repeat (4) @(posedge mclk_i);
    chk("strap adv", 32'h1, {30'h0, ctrl_o.adv_full, ctrl_o.adv_half});
    rdc(8'h24, 32'h0100);
    $display("counter and reset tests done");
    print_verdict();
  end
endmodule
`default_nettype wire
